// File: common/sobs_regs.vh
`ifndef SOBS_REGS_VH
`define SOBS_REGS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SOBS_A_CTRL 5'h00
`define SOBS_A_SEQ 5'h04
`define SOBS_A_STALL 5'h08
`define SOBS_A_RUN 5'h0c
`define SOBS_A_REGEN 5'h10
`define SOBS_A_TORQ 5'h14
`define SOBS_A_STAT 5'h18
`define SOBS_A_IRQ 5'h1c
`define SOBS_A_MASK 5'h20
// ----------------------------------------
// Field limits and reset values
// ----------------------------------------
`define SOBS_SEQ_MAX 4'h9
`define SOBS_DLY_MAX 7'h64
`define SOBS_REGEN_MAX 2'h3
`define SOBS_SEQ_RST 4'h0
`define SOBS_REGEN_RST 2'h0
`define SOBS_SPEED_LOW 16'h001e
`define SOBS_RATIO_TRIP 7'h0a
`define SOBS_RATIO_BUILTIN 7'h01
`define SOBS_RATIO_WIN 7'h64
// ----------------------------------------
// Timing
// ----------------------------------------
`define SOBS_CLK_HZ 25000000
`define SOBS_TICK_US 2000
`define SOBS_TICK_CYC ((`SOBS_CLK_HZ / 1000000) * `SOBS_TICK_US)
// ----------------------------------------
// Interrupt bit positions
// ----------------------------------------
`define SOBS_EV_OFF 0
`define SOBS_EV_BRK 1
`define SOBS_EV_DEEN 2
`define SOBS_EV_TRIP 3
// ----------------------------------------
// Bus responses
// ----------------------------------------
`define SOBS_RESP_OK 2'h0
`define SOBS_RESP_ERR 2'h2
`endif

// File: logic/sobs_tick.v
`include "sobs_regs.vh"
`default_nettype none
// ----------------------------------------
// 2 ms tick generator
// ----------------------------------------
module sobs_tick #(
    parameter TICK_CYC = `SOBS_TICK_CYC
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Tick out
    output reg tick
);
    reg [31:0] cnt_r;
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= 32'h0;
            tick <= 1'b0;
        end else if (cnt_r == TICK_CYC - 1) begin
            cnt_r <= 32'h0;
            tick <= 1'b1; // R13
        end else begin
            cnt_r <= cnt_r + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule // sobs_tick
`default_nettype wire

// File: logic/sobs_seq.v
// Design decisions made here: the AXI4-Lite register port and the address map.
`include "sobs_regs.vh"
`default_nettype none
// Operation
// R1 - At servo-off the sequence setting (0..9, default 0) picks decel, stall and counter action.
// R2 - Each sequence value maps to the same actions as the main-power-off sequence table.
// R3 - Stalled servo-off drops brake, then de-energizes after the stall delay (0..100 x 2 ms).
// R4 - Running servo-off waits the running delay (0..100 x 2 ms) before dropping brake release.
// R5 - The running delay ends early once speed falls below 30 r/min.
// R6 - Software should set the stall delay at least the brake actuation delay.
// R7 - Regen select 0 uses the built-in resistor with overload protection near 1 percent duty.
// R8 - Regen select 1 trips regen overload when the active ratio exceeds 10 percent.
// R9 - Regen select 2 runs regen processing but never trips.
// R10 - Regen select 3 disables regen processing and protection.
// R11 - The regen selection takes effect only at the next control power-up.
// R12 - Sequence 8 or 9 decelerates at the emergency torque limit, zero meaning the normal limit.
// R13 - Delays count whole 2 ms ticks derived from the clock, zero adding no delay. The tick here runs free, so the first tick of a delay may be partial.
module sobs_seq #(
    parameter TICK_CYC = `SOBS_TICK_CYC
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Write address
    input wire [4:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // Write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // Write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // Read address
    input wire [4:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // Read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Drive side
    input wire servo_enable_input,
    input wire [15:0] motor_speed,
    input wire regen_active,
    input wire power_on_pulse,
    output reg brake_release_output,
    output reg motor_energized,
    output reg dynamic_braking,
    output reg emergency_torque_active,
    output reg [8:0] torque_limit_out,
    output reg clear_deviation,
    output reg regen_enable,
    output reg regen_overload_trip,
    output reg irq
);
    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam ST_ON = 2'h0;
    localparam ST_RUNWAIT = 2'h1;
    localparam ST_STALLWAIT = 2'h2;
    localparam ST_OFF = 2'h3;

    wire tick;
    reg [1:0] st_r;
    reg [6:0] dly_r;
    reg en_d_r;
    reg [3:0] seq_r;
    reg [6:0] stall_r;
    reg [6:0] run_r;
    reg [1:0] regen_sel_r;
    reg [1:0] regen_act_r;
    reg [8:0] torq_r;
    reg [8:0] norm_torq_r;
    reg [3:0] stat_r;
    reg [3:0] mask_r;
    reg [3:0] ev_r;
    reg [6:0] win_r;
    reg [6:0] act_cnt_r;
    reg [4:0] awaddr_r;
    reg [31:0] wdata_r;
    reg aw_have_r;
    reg w_have_r;
    reg [31:0] rd_nxt;
    reg rd_ok;
    reg decel_dyn;
    reg after_dyn;
    reg clr_dev;

    sobs_tick #(.TICK_CYC(TICK_CYC)) u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick)
    );

    // ----------------------------------------
    // Sequence table, shared with power-off
    // ----------------------------------------
    always @* begin
        decel_dyn = 1'b1;
        after_dyn = 1'b1;
        clr_dev = 1'b1;
        case (seq_r) // R1 R2
            4'h0: begin decel_dyn = 1'b1; after_dyn = 1'b1; clr_dev = 1'b1; end
            4'h1: begin decel_dyn = 1'b0; after_dyn = 1'b1; clr_dev = 1'b1; end
            4'h2: begin decel_dyn = 1'b1; after_dyn = 1'b0; clr_dev = 1'b1; end
            4'h3: begin decel_dyn = 1'b0; after_dyn = 1'b0; clr_dev = 1'b1; end
            4'h4: begin decel_dyn = 1'b1; after_dyn = 1'b1; clr_dev = 1'b0; end
            4'h5: begin decel_dyn = 1'b0; after_dyn = 1'b1; clr_dev = 1'b0; end
            4'h6: begin decel_dyn = 1'b1; after_dyn = 1'b0; clr_dev = 1'b0; end
            4'h7: begin decel_dyn = 1'b0; after_dyn = 1'b0; clr_dev = 1'b0; end
            default: begin decel_dyn = 1'b0; after_dyn = 1'b1; clr_dev = 1'b1; end
        endcase
    end

    wire estop_seq = (seq_r >= 4'h8); // R12
    wire stalled = (motor_speed < `SOBS_SPEED_LOW);

    // ----------------------------------------
    // Servo-off sequencer
    // ----------------------------------------
    always @(posedge aclk) begin
        ev_r <= 4'h0;
        if (!aresetn) begin
            st_r <= ST_OFF;
            dly_r <= 7'h0;
            en_d_r <= 1'b0;
            brake_release_output <= 1'b0;
            motor_energized <= 1'b0;
            dynamic_braking <= 1'b0;
            emergency_torque_active <= 1'b0;
            torque_limit_out <= 9'h0;
            clear_deviation <= 1'b0;
        end else begin
            en_d_r <= servo_enable_input;
            clear_deviation <= 1'b0;
            torque_limit_out <= emergency_torque_active && torq_r != 9'h0 ?
                torq_r : norm_torq_r; // R12
            case (st_r)
                ST_ON: begin
                    if (en_d_r && !servo_enable_input) begin
                        ev_r[`SOBS_EV_OFF] <= 1'b1;
                        clear_deviation <= clr_dev; // R1
                        if (stalled) begin
                            brake_release_output <= 1'b0; // R3
                            ev_r[`SOBS_EV_BRK] <= 1'b1;
                            dly_r <= stall_r;
                            st_r <= ST_STALLWAIT;
                        end else begin
                            motor_energized <= estop_seq;
                            emergency_torque_active <= estop_seq; // R12
                            dynamic_braking <= decel_dyn && !estop_seq;
                            dly_r <= run_r; // R4
                            st_r <= ST_RUNWAIT;
                        end
                    end
                end
                ST_RUNWAIT: begin
                    if (dly_r == 7'h0 || stalled) begin // R5 R13
                        brake_release_output <= 1'b0; // R4
                        ev_r[`SOBS_EV_BRK] <= 1'b1;
                        ev_r[`SOBS_EV_DEEN] <= 1'b1;
                        motor_energized <= 1'b0;
                        emergency_torque_active <= 1'b0;
                        dynamic_braking <= after_dyn;
                        st_r <= ST_OFF;
                    end else if (tick) begin
                        dly_r <= dly_r - 7'h1; // R13
                    end
                end
                ST_STALLWAIT: begin
                    if (dly_r == 7'h0) begin // R3 R6
                        motor_energized <= 1'b0;
                        dynamic_braking <= after_dyn;
                        ev_r[`SOBS_EV_DEEN] <= 1'b1;
                        st_r <= ST_OFF;
                    end else if (tick) begin
                        dly_r <= dly_r - 7'h1; // R13
                    end
                end
                ST_OFF: begin
                    if (servo_enable_input && !regen_overload_trip) begin
                        motor_energized <= 1'b1;
                        brake_release_output <= 1'b1;
                        dynamic_braking <= 1'b0;
                        st_r <= ST_ON;
                    end
                end
                default: st_r <= ST_OFF;
            endcase
        end
    end

    // ----------------------------------------
    // Regenerative control
    // ----------------------------------------
    // Ratio measured over 100 ticks (200 ms) windows; coarse but cheap.
    always @(posedge aclk) begin
        if (!aresetn) begin
            regen_act_r <= `SOBS_REGEN_RST;
            regen_enable <= 1'b0;
            regen_overload_trip <= 1'b0;
            win_r <= 7'h0;
            act_cnt_r <= 7'h0;
        end else begin
            if (power_on_pulse)
                regen_act_r <= regen_sel_r; // R11
            regen_enable <= (regen_act_r != 2'h3); // R10
            if (tick) begin
                if (win_r == `SOBS_RATIO_WIN - 7'h1) begin
                    win_r <= 7'h0;
                    act_cnt_r <= 7'h0;
                end else begin
                    win_r <= win_r + 7'h1;
                    if (regen_active && regen_act_r != 2'h3)
                        act_cnt_r <= act_cnt_r + 7'h1;
                end
            end
            if (power_on_pulse)
                regen_overload_trip <= 1'b0; // R11
            else if (regen_act_r == 2'h0 && act_cnt_r > `SOBS_RATIO_BUILTIN)
                regen_overload_trip <= 1'b1; // R7
            else if (regen_act_r == 2'h1 && act_cnt_r > `SOBS_RATIO_TRIP)
                regen_overload_trip <= 1'b1; // R8 R9 R10
        end
    end

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    wire do_wr = aw_have_r && w_have_r && !s_axi_bvalid;
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SOBS_RESP_OK;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= 5'h0;
            wdata_r <= 32'h0;
            seq_r <= `SOBS_SEQ_RST;
            stall_r <= 7'h0;
            run_r <= 7'h0;
            regen_sel_r <= `SOBS_REGEN_RST;
            torq_r <= 9'h0;
            norm_torq_r <= 9'h0;
            stat_r <= 4'h0;
            mask_r <= 4'h0;
            irq <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_have_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                wdata_r <= s_axi_wdata;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            stat_r <= stat_r | ev_r;
            if (do_wr) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `SOBS_RESP_OK;
                case (awaddr_r)
                    `SOBS_A_SEQ: if (wdata_r[3:0] <= `SOBS_SEQ_MAX) seq_r <= wdata_r[3:0];
                    `SOBS_A_STALL: if (wdata_r[6:0] <= `SOBS_DLY_MAX) stall_r <= wdata_r[6:0];
                    `SOBS_A_RUN: if (wdata_r[6:0] <= `SOBS_DLY_MAX) run_r <= wdata_r[6:0];
                    `SOBS_A_REGEN: regen_sel_r <= wdata_r[1:0];
                    `SOBS_A_TORQ: begin
                        torq_r <= wdata_r[8:0];
                        norm_torq_r <= wdata_r[24:16];
                    end
                    `SOBS_A_IRQ: stat_r <= (stat_r & ~wdata_r[3:0]) | ev_r; // Set wins
                    `SOBS_A_MASK: mask_r <= wdata_r[3:0];
                    `SOBS_A_CTRL: s_axi_bresp <= `SOBS_RESP_OK;
                    `SOBS_A_STAT: s_axi_bresp <= `SOBS_RESP_OK;
                    default: s_axi_bresp <= `SOBS_RESP_ERR;
                endcase
            end
            irq <= |(stat_r & mask_r);
        end
    end

    always @* begin
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `SOBS_A_CTRL: rd_nxt = {31'h0, servo_enable_input};
            `SOBS_A_SEQ: rd_nxt = {28'h0, seq_r};
            `SOBS_A_STALL: rd_nxt = {25'h0, stall_r};
            `SOBS_A_RUN: rd_nxt = {25'h0, run_r};
            `SOBS_A_REGEN: rd_nxt = {26'h0, regen_act_r, 2'h0, regen_sel_r};
            `SOBS_A_TORQ: rd_nxt = {7'h0, norm_torq_r, 7'h0, torq_r};
            `SOBS_A_STAT: rd_nxt = {24'h0, regen_overload_trip, dynamic_braking,
                motor_energized, brake_release_output, 2'h0, st_r};
            `SOBS_A_IRQ: rd_nxt = {28'h0, stat_r};
            `SOBS_A_MASK: rd_nxt = {28'h0, mask_r};
            default: begin
                rd_nxt = 32'h0;
                rd_ok = 1'b0;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `SOBS_RESP_OK;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_nxt;
                s_axi_rresp <= rd_ok ? `SOBS_RESP_OK : `SOBS_RESP_ERR;
            end
        end
    end
endmodule // sobs_seq
`default_nettype wire

// File: verif/sobs_seq_props.sv
`default_nettype none
// ----------------------------------------
// Servo-off sequencer checker
// ----------------------------------------
module sobs_seq_props #(
    parameter int TICK_CYC = 50000
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Drive side
    input wire logic servo_enable_input,
    input wire logic [15:0] motor_speed,
    input wire logic power_on_pulse,
    input wire logic brake_release_output,
    input wire logic motor_energized,
    input wire logic emergency_torque_active,
    input wire logic clear_deviation,
    input wire logic regen_enable,
    input wire logic regen_overload_trip
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Full delay plus a partial first tick and the detect pipeline
    localparam int MAX_OFF = 101 * TICK_CYC + 8;
    int off_cnt_r;
    always_ff @(posedge aclk) begin
        if (!aresetn || servo_enable_input || !(brake_release_output || motor_energized)) begin
            off_cnt_r <= 0;
        end else begin
            off_cnt_r <= off_cnt_r + 1;
        end
    end
    property p_brk_first;
        $fell(motor_energized) && $past(motor_speed) < 16'h001e |-> !brake_release_output;
    endproperty
    a_brk_first: assert property (p_brk_first)
        else $error("motor de-energized while brake released");
    property p_slow_brk;
        (!servo_enable_input && motor_speed < 16'h001e) [*5] |-> !brake_release_output;
    endproperty
    a_slow_brk: assert property (p_slow_brk)
        else $error("brake still released below stall speed");
    property p_off_bound;
        off_cnt_r < MAX_OFF;
    endproperty
    a_off_bound: assert property (p_off_bound)
        else $error("servo-off sequence overran the longest delay");
    property p_trip_sticky;
        regen_overload_trip && !power_on_pulse |=> regen_overload_trip;
    endproperty
    a_trip_sticky: assert property (p_trip_sticky)
        else $error("regen trip dropped without power-up");
    property p_trip_en;
        $rose(regen_overload_trip) |-> regen_enable;
    endproperty
    a_trip_en: assert property (p_trip_en)
        else $error("regen trip with processing inactive");
    property p_clr_pulse;
        $rose(clear_deviation) |-> !servo_enable_input ##1 !clear_deviation;
    endproperty
    a_clr_pulse: assert property (p_clr_pulse)
        else $error("deviation clear not a servo-off pulse");
    property p_estop;
        emergency_torque_active |-> motor_energized && !servo_enable_input;
    endproperty
    a_estop: assert property (p_estop)
        else $error("estop torque outside powered deceleration");
    property p_restart;
        $rose(motor_energized) |-> servo_enable_input && !regen_overload_trip;
    endproperty
    a_restart: assert property (p_restart)
        else $error("motor energized without servo enable");
    c_stall: cover property ($fell(motor_energized) && motor_speed < 16'h001e);
    c_trip: cover property ($rose(regen_overload_trip));
    c_estop: cover property ($rose(emergency_torque_active));
endmodule // sobs_seq_props

bind sobs_seq sobs_seq_props #(.TICK_CYC(TICK_CYC)) u_props (
    .aclk, .aresetn, .servo_enable_input, .motor_speed, .power_on_pulse, .brake_release_output,
    .motor_energized, .emergency_torque_active, .clear_deviation, .regen_enable,
    .regen_overload_trip
);
`default_nettype wire

// File: verif/sobs_motor.sv
`default_nettype none
// ----------------------------------------
// Motor, holding brake and regen circuit
// ----------------------------------------
module sobs_motor #(
    parameter int BRAKE_ACT_CYC = 3
) (
    // Clock
    input wire logic aclk,
    // From the drive
    input wire logic motor_energized,
    input wire logic brake_release_output,
    // Bench commands
    input wire logic [15:0] speed_cmd,
    input wire logic regen_req,
    // To the drive
    output logic [15:0] motor_speed,
    output logic regen_active
);
    timeunit 1ns;
    timeprecision 1ps;
    int brake_age_r = 0;
    logic [15:0] speed_r = 16'h0000;
    // The brake grips only after its actuation delay; until then the load coasts
    always_ff @(posedge aclk) begin
        brake_age_r <= brake_release_output ? 0 : brake_age_r + 1;
        if (motor_energized && brake_release_output) begin
            speed_r <= speed_cmd;
        end else if (brake_age_r >= BRAKE_ACT_CYC) begin
            speed_r <= (speed_r > 16'h0028) ? speed_r - 16'h0028 : 16'h0000;
        end else begin
            speed_r <= (speed_r > 16'h0004) ? speed_r - 16'h0004 : 16'h0000;
        end
    end
    assign motor_speed = speed_r;
    assign regen_active = regen_req;
endmodule // sobs_motor
`default_nettype wire

// File: verif/testbench.sv
`include "sobs_regs.vh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T = 10;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, servo_enable_input = 0, regen_active, power_on_pulse = 0, regen_req = 0;
    logic [1:0] s_axi_bresp, s_axi_rresp, prev;
    logic [15:0] motor_speed, speed_cmd = 16'h0000;
    logic brake_release_output, motor_energized, dynamic_braking, emergency_torque_active;
    logic clear_deviation, regen_enable, regen_overload_trip, irq;
    logic [8:0] torque_limit_out;
    logic [31:0] seed = 32'h0000000c;
    int bad_count = 0;
    int check_count = 0;
    sobs_seq #(.TICK_CYC(T)) dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .servo_enable_input, .motor_speed, .regen_active, .power_on_pulse, .brake_release_output,
        .motor_energized, .dynamic_braking, .emergency_torque_active, .torque_limit_out,
        .clear_deviation, .regen_enable, .regen_overload_trip, .irq
    );
    sobs_motor motor (.aclk, .motor_energized, .brake_release_output, .speed_cmd, .regen_req,
        .motor_speed, .regen_active);
    always #20 aclk = ~aclk;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // A delay may run up to one tick short, since the first tick is partial
    function automatic logic in_win(int got, int dly);
        return got >= (dly - 1) * T && got <= dly * T + 4;
    endfunction
    // The motor dropping below 30 r/min may cut the running delay short
    function automatic logic run_ok(int got, int dly, int fall);
        return got <= dly * T + 4 && got <= fall + 4 && (got >= (dly - 1) * T || got >= fall - 1);
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        if (bad_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask
    task automatic servo_cycle(input int s, input int stall, input int run, input logic [15:0] spd,
            input logic drop);
        int brk_at, t_off, fall;
        logic clr, est, dec;
        logic [8:0] tq;
        wr(`SOBS_A_SEQ, s);
        wr(`SOBS_A_STALL, stall);
        wr(`SOBS_A_RUN, run);
        speed_cmd <= spd;
        servo_enable_input <= 1'b1;
        repeat (20) @(posedge aclk);
        check("servo_on", {brake_release_output, motor_energized}, 2'h3);
        servo_enable_input <= 1'b0;
        if (drop) speed_cmd <= 16'h0000;
        brk_at = -1;
        t_off = -1;
        clr = 0;
        est = 0;
        dec = 0;
        tq = 9'h0;
        // Coasting sheds 4 r/min a cycle; under seq 8 and 9 the drive holds the speed
        fall = drop ? 2 : s > 7 ? 100000 : (spd - 30) / 4 + 3;
        for (int n = 0; n < 1200 && (t_off < 0 || brk_at < 0); n++) begin
            @(posedge aclk);
            if (brk_at < 0 && !brake_release_output) brk_at = n;
            if (t_off < 0 && !motor_energized) t_off = n;
            if (n == 1) dec = dynamic_braking;
            if (n == 2) tq = torque_limit_out;
            clr |= clear_deviation;
            est |= emergency_torque_active;
        end
        repeat (40) begin
            @(posedge aclk);
            clr |= clear_deviation;
        end
        check("clear", clr, s < 4 || s > 7);
        check("dyn_after", dynamic_braking, s > 7 || s % 4 < 2);
        if (spd < 16'h001e) begin
            check("stall_brk", brk_at <= 4, 1);
            check("stall_gap", in_win(t_off - brk_at, stall), 1);
        end else begin
            check("run_off", t_off, s > 7 ? brk_at : 1);
            check("run_time", run_ok(brk_at, run, fall), 1);
            check("decel_dyn", dec, s < 8 && s % 2 == 0);
            check("torque", tq, s > 7 ? 9'h096 : 9'h0c8);
            check("estop", est, s > 7);
        end
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check("reset_out", {brake_release_output, motor_energized, irq}, 3'h0);
        wr(`SOBS_A_SEQ, 10);
        rd_reg(`SOBS_A_SEQ, rd);
        check("seq_range", rd, `SOBS_SEQ_RST);
        wr(`SOBS_A_STALL, 101);
        rd_reg(`SOBS_A_STALL, rd);
        check("stall_range", rd, 0);
        wr(`SOBS_A_STALL, 100);
        rd_reg(`SOBS_A_STALL, rd);
        check("stall_max", rd, 100);
        wr(`SOBS_A_TORQ, 32'h00c8_0096);
        servo_cycle(0, 0, 0, 16'h0000, 0);
        check("irq_masked", irq, 0);
        rd_reg(`SOBS_A_IRQ, rd);
        check("irq_stat", rd[2:0], 3'h7);
        wr(`SOBS_A_MASK, 7);
        repeat (3) @(posedge aclk);
        check("irq_on", irq, 1);
        wr(`SOBS_A_IRQ, 7);
        repeat (3) @(posedge aclk);
        check("irq_clr", irq, 0);
        for (int s = 0; s <= 9; s++) begin
            servo_cycle(s, s == 0 ? 0 : s == 9 ? 100 : rnd() % 101, 0, 16'(rnd() % 30), 0);
            servo_cycle(s, 0, s == 0 ? 100 : s == 9 ? 0 : rnd() % 101,
                s == 1 ? 16'h001e : 16'(30 + rnd() % 900), 0);
        end
        servo_cycle(0, 0, 100, 16'h01f4, 1);
        prev = 2'h0;
        for (int i = 0; i < 4; i++) begin
            wr(`SOBS_A_REGEN, (i + 1) % 4);
            rd_reg(`SOBS_A_REGEN, rd);
            check("regen_pend", rd[5:0], {prev, 2'h0, 2'((i + 1) % 4)});
            prev = 2'((i + 1) % 4);
            power_on_pulse <= 1'b1;
            @(posedge aclk);
            power_on_pulse <= 1'b0;
            regen_req <= 1'b1;
            repeat (2500) @(posedge aclk);
            check("regen_en", regen_enable, prev != 2'h3);
            check("regen_trip", regen_overload_trip, prev < 2'h2);
            regen_req <= 1'b0;
        end
        final_report();
    end
    initial begin
        repeat (60000) @(posedge aclk);
        bad_count++;
        final_report();
    end
endmodule // testbench
`default_nettype wire
